// file: include/vic_pkg.sv
// constants shared by the vectored interrupt controller files
// assumes one 40 MHz clock and a plain strobed register port
package vic_pkg;
	localparam int NUM_SRC = 64;
	localparam int NUM_VEC = 44;
	localparam int NUM_EXT = 5;
	localparam int LVL_W = 5;
	localparam int PRI_W = 3;
	localparam int SUB_W = 2;
	localparam int VEC_W = 6;
	localparam int SPC_W = 10;
	localparam int ADDR_W = 8;
	localparam int PRI_WORDS = 11;
	localparam int VEC_PER_WORD = 4;
	localparam int LVL_STEP = 4;
	localparam logic [VEC_W-1:0] SHARED_VEC = 6'h2B;
	localparam logic [PRI_W-1:0] PRI_OFF = 3'h0;
	localparam logic [VEC_W-1:0] SINGLE_VEC = 6'h00;

	localparam logic [ADDR_W-1:0] OFS_FLAG0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAG1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_EN0 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EN1 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_BASE = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_FLAG0_SET = 8'h50;
	localparam logic [ADDR_W-1:0] OFS_FLAG0_CLR = 8'h54;
	localparam logic [ADDR_W-1:0] OFS_FLAG1_SET = 8'h58;
	localparam logic [ADDR_W-1:0] OFS_FLAG1_CLR = 8'h5C;
	localparam logic [ADDR_W-1:0] OFS_LEVEL0 = 8'h20;

	localparam int CTRL_MULTI_BIT = 0;
	localparam int CTRL_POL_LSB = 8;
	localparam int CTRL_SPC_LSB = 16;
	localparam int STAT_VEC_LSB = 0;
	localparam int STAT_SUB_LSB = 8;
	localparam int STAT_PRI_LSB = 10;
	localparam int STAT_IRQ_BIT = 16;
	localparam int LVL_PRI_LSB = 2;
	localparam int BYTE_W = 8;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// file: src/vector_arbiter.sv
// ranks pending vectors by priority, then subpriority, then index
// assumes pending and level vectors are stable within one cycle
`timescale 1ns/10ps
module vector_arbiter
	import vic_pkg::*;
(
	input wire logic [NUM_VEC-1:0] pending,
	input wire logic [NUM_VEC*LVL_W-1:0] level,
	output logic found,
	output logic [VEC_W-1:0] winVec,
	output logic [PRI_W-1:0] winPri,
	output logic [SUB_W-1:0] winSub
);
	always_comb begin
		logic [LVL_W-1:0] best;
		logic [LVL_W-1:0] cand;
		best = '0;
		cand = '0;
		found = 1'b0;
		winVec = '0;
		for (int v = 0; v < NUM_VEC; v++) begin
			cand = level[v*LVL_W +: LVL_W];
			// strict compare keeps the lowest index on a tie
			if (pending[v] && (!found || cand > best)) begin
				found = 1'b1;
				best = cand;
				winVec = VEC_W'(v);
			end
		end
		winPri = best[LVL_W-1:LVL_PRI_LSB];
		winSub = best[SUB_W-1:0];
	end
endmodule // vector_arbiter

// file: src/vectored_interrupt_controller.sv
// vectored interrupt controller: flags, enables, levels, vector out
// assumes synchronous inputs on mclk and a strobed register port
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Operation
// - peripheral events become requests outside the core
// - rank pending requests before informing the core
// - sixty-four sources, each flag and enable
// - sources map onto forty-four vectors
// - single-vector shared entry, multi-vector distinct entries
// - five external pins with edge polarity
// - seven usable priority levels per vector
// - four subpriority levels break ties
// - software write to flag raises request
// - programmable vector table base address
// - programmable spacing between vector entries
// - no shadow register set ever selected
// - flag register bits readable writable, reset zero
// - enable register bits readable writable, reset zero
module vectored_interrupt_controller
	import vic_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [31:0] regRdData,
	input wire logic [NUM_SRC-1:0] periphEvent,
	input wire logic [NUM_EXT-1:0] extIntPin,
	output logic cpuIrq,
	output logic [VEC_W-1:0] cpuVector,
	output logic [PRI_W-1:0] cpuPriority,
	output logic [31:0] cpuVectorAddr
);
	typedef struct packed {
		logic [NUM_SRC-1:0] flag;
		logic [NUM_SRC-1:0] enable;
		logic multiVec;
		logic [NUM_EXT-1:0] extPol;
		logic [SPC_W-1:0] spacing;
		logic [31:0] tableBase;
		logic [NUM_VEC*LVL_W-1:0] level;
		logic [NUM_EXT-1:0] extPrev;
		logic [31:0] rdData;
		logic irq;
		logic [VEC_W-1:0] vec;
		logic [PRI_W-1:0] pri;
		logic [SUB_W-1:0] sub;
		logic [VEC_W-1:0] natVec;
		logic [31:0] vecAddr;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	logic [NUM_SRC-1:0] activeSrc;
	logic [NUM_VEC-1:0] vecReq;
	logic [NUM_VEC-1:0] vecPending;
	logic [NUM_EXT-1:0] extEdge;
	logic [NUM_SRC-1:0] srcEvent;
	logic arbFound;
	logic [VEC_W-1:0] arbVec;
	logic [PRI_W-1:0] arbPri;
	logic [SUB_W-1:0] arbSub;
	logic [PRI_W-1:0] vecPri [NUM_VEC];
	logic [NUM_EXT-1:0] extRise;
	logic [NUM_EXT-1:0] extFall;

	// register select decoded once, shared by the write and read paths
	localparam int WSEL_W = $clog2(PRI_WORDS);
	typedef enum {
		SEL_NONE,
		SEL_FLAG0,
		SEL_FLAG1,
		SEL_EN0,
		SEL_EN1,
		SEL_CTRL,
		SEL_BASE,
		SEL_STATUS,
		SEL_FLAG0_SET,
		SEL_FLAG0_CLR,
		SEL_FLAG1_SET,
		SEL_FLAG1_CLR,
		SEL_LEVEL
	} reg_sel_t;
	reg_sel_t regSel;
	logic [WSEL_W-1:0] levelWord;

	// a flag that is latched but disabled is held and simply not shown
	assign activeSrc = state_r.flag & state_r.enable;

	// per-vector request: low sources own a vector, the rest share one
	genvar gv;
	generate
		for (gv = 0; gv < NUM_VEC; gv++) begin : g_vec
			if (gv < NUM_VEC - 1) begin : g_own
				assign vecReq[gv] = activeSrc[gv];
			end else begin : g_shared
				assign vecReq[gv] = |activeSrc[NUM_SRC-1:gv];
			end
			assign vecPri[gv] =
				state_r.level[gv*LVL_W+LVL_PRI_LSB +: PRI_W];
			// priority zero means the vector is switched off
			assign vecPending[gv] = vecReq[gv] &&
				(vecPri[gv] != PRI_OFF);
		end
	endgenerate

	// external pins: polarity 1 catches a rise, 0 catches a fall
	genvar ge;
	generate
		for (ge = 0; ge < NUM_EXT; ge++) begin : g_ext
			assign extRise[ge] = extIntPin[ge] && !state_r.extPrev[ge];
			assign extFall[ge] = !extIntPin[ge] && state_r.extPrev[ge];
			assign extEdge[ge] = state_r.extPol[ge] ?
				extRise[ge] : extFall[ge];
		end
	endgenerate

	// the external pins drive the lowest source numbers
	assign srcEvent = periphEvent |
		{{(NUM_SRC-NUM_EXT){1'b0}}, extEdge};

	vector_arbiter u_arb (
		.pending(vecPending),
		.level(state_r.level),
		.found(arbFound),
		.winVec(arbVec),
		.winPri(arbPri),
		.winSub(arbSub)
	);

	// fixed registers win; level words sit at 0x20 to 0x48, other addresses are unmapped
	always_comb begin
		regSel = SEL_NONE;
		levelWord = '0;
		if (regAddr == OFS_FLAG0) begin
			regSel = SEL_FLAG0;
		end else if (regAddr == OFS_FLAG1) begin
			regSel = SEL_FLAG1;
		end else if (regAddr == OFS_EN0) begin
			regSel = SEL_EN0;
		end else if (regAddr == OFS_EN1) begin
			regSel = SEL_EN1;
		end else if (regAddr == OFS_CTRL) begin
			regSel = SEL_CTRL;
		end else if (regAddr == OFS_BASE) begin
			regSel = SEL_BASE;
		end else if (regAddr == OFS_STATUS) begin
			regSel = SEL_STATUS;
		end else if (regAddr == OFS_FLAG0_SET) begin
			regSel = SEL_FLAG0_SET;
		end else if (regAddr == OFS_FLAG0_CLR) begin
			regSel = SEL_FLAG0_CLR;
		end else if (regAddr == OFS_FLAG1_SET) begin
			regSel = SEL_FLAG1_SET;
		end else if (regAddr == OFS_FLAG1_CLR) begin
			regSel = SEL_FLAG1_CLR;
		end else begin
			// set and clear words sit above the level block so that
			// every vector, the shared one too, keeps a reachable level
			for (int w = 0; w < PRI_WORDS; w++) begin
				if (regAddr == ADDR_W'(OFS_LEVEL0 + LVL_STEP*w)) begin
					regSel = SEL_LEVEL;
					levelWord = WSEL_W'(w);
				end
			end
		end
	end

	always_comb begin
		logic [31:0] rdWord;
		logic [31:0] spanAddr;
		int lvlBase;
		state_nxt = state_r;
		rdWord = RST_WORD;
		spanAddr = RST_WORD;
		lvlBase = int'(levelWord) * VEC_PER_WORD;

		// register writes; the hardware set below is applied after them
		if (regWrStrobe) begin
			case (regSel)
				SEL_FLAG0: begin
					state_nxt.flag[31:0] = regWrData;
				end

				SEL_FLAG1: begin
					state_nxt.flag[63:32] = regWrData;
				end

				// set and clear words avoid a read-modify-write race
				SEL_FLAG0_SET: begin
					state_nxt.flag[31:0] = state_r.flag[31:0] |
						regWrData;
				end

				SEL_FLAG1_SET: begin
					state_nxt.flag[63:32] = state_r.flag[63:32] |
						regWrData;
				end

				SEL_FLAG0_CLR: begin
					state_nxt.flag[31:0] = state_r.flag[31:0] &
						~regWrData;
				end

				SEL_FLAG1_CLR: begin
					state_nxt.flag[63:32] = state_r.flag[63:32] &
						~regWrData;
				end

				SEL_EN0: begin
					state_nxt.enable[31:0] = regWrData;
				end

				SEL_EN1: begin
					state_nxt.enable[63:32] = regWrData;
				end

				SEL_CTRL: begin
					state_nxt.multiVec =
						regWrData[CTRL_MULTI_BIT];
					state_nxt.extPol =
						regWrData[CTRL_POL_LSB +: NUM_EXT];
					state_nxt.spacing =
						regWrData[CTRL_SPC_LSB +: SPC_W];
				end

				SEL_BASE: begin
					state_nxt.tableBase = regWrData;
				end

				SEL_LEVEL: begin
					for (int b = 0; b < VEC_PER_WORD; b++) begin
						state_nxt.level[(lvlBase + b)*LVL_W +: LVL_W] =
							regWrData[b*BYTE_W +: LVL_W];
					end
				end

				default: begin
					// status and unmapped addresses ignore writes
				end
			endcase
		end

		// a hardware event in the same cycle as a clear still lands
		state_nxt.flag = state_nxt.flag | srcEvent;
		state_nxt.extPrev = extIntPin;

		// reads: data stand only in the cycle after the strobe
		if (regRdStrobe) begin
			case (regSel)
				SEL_FLAG0: begin
					rdWord = state_r.flag[31:0];
				end

				SEL_FLAG1: begin
					rdWord = state_r.flag[63:32];
				end

				SEL_EN0: begin
					rdWord = state_r.enable[31:0];
				end

				SEL_EN1: begin
					rdWord = state_r.enable[63:32];
				end

				SEL_CTRL: begin
					rdWord[CTRL_MULTI_BIT] = state_r.multiVec;
					rdWord[CTRL_POL_LSB +: NUM_EXT] = state_r.extPol;
					rdWord[CTRL_SPC_LSB +: SPC_W] = state_r.spacing;
				end

				SEL_BASE: begin
					rdWord = state_r.tableBase;
				end

				SEL_STATUS: begin
					rdWord[STAT_VEC_LSB +: VEC_W] = state_r.natVec;
					rdWord[STAT_SUB_LSB +: SUB_W] = state_r.sub;
					rdWord[STAT_PRI_LSB +: PRI_W] = state_r.pri;
					rdWord[STAT_IRQ_BIT] = state_r.irq;
				end

				SEL_LEVEL: begin
					for (int b = 0; b < VEC_PER_WORD; b++) begin
						rdWord[b*BYTE_W +: LVL_W] =
							state_r.level[(lvlBase + b)*LVL_W +: LVL_W];
					end
				end

				// write-only set and clear words read back as zero
				default: begin
					rdWord = RST_WORD;
				end
			endcase
		end
		state_nxt.rdData = rdWord;

		// the core only sees the winner after ranking
		state_nxt.irq = arbFound;
		state_nxt.natVec = arbFound ? arbVec : SINGLE_VEC;
		state_nxt.pri = arbFound ? arbPri : PRI_OFF;
		state_nxt.sub = arbFound ? arbSub : '0;

		// entry = base + vector * spacing; single mode shares the base
		spanAddr = 32'(arbVec) * 32'(state_r.spacing);
		if (state_r.multiVec && arbFound) begin
			state_nxt.vec = arbVec;
			state_nxt.vecAddr = state_r.tableBase + spanAddr;
		end else begin
			state_nxt.vec = SINGLE_VEC;
			state_nxt.vecAddr = state_r.tableBase;
		end
		// there is no register-set select toward the core at all
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign regRdData = state_r.rdData;
	assign cpuIrq = state_r.irq;
	assign cpuVector = state_r.vec;
	assign cpuPriority = state_r.pri;
	assign cpuVectorAddr = state_r.vecAddr;
endmodule // vectored_interrupt_controller

// file: testbench/vic_chk.sv
// port-level assertions for the interrupt controller
// assumes one clock; bound to every controller instance
`timescale 1ns/10ps
module vic_chk
	import vic_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	input wire logic [31:0] regRdData,
	input wire logic [NUM_SRC-1:0] periphEvent,
	input wire logic [NUM_EXT-1:0] extIntPin,
	input wire logic cpuIrq,
	input wire logic [VEC_W-1:0] cpuVector,
	input wire logic [PRI_W-1:0] cpuPriority,
	input wire logic [31:0] cpuVectorAddr
);
	logic [2:0] quietCnt_r;
	logic [NUM_EXT-1:0] pinPrev_r;
	logic busy;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// reads move only the read data, so they do not reset the quiet count
	assign busy = regWrStrobe || (|periphEvent) || (extIntPin != pinPrev_r);
	always_ff @(posedge mclk) begin
		pinPrev_r <= extIntPin;
		if (!resetn || busy)
			quietCnt_r <= 3'h0;
		else if (quietCnt_r != 3'h7)
			quietCnt_r <= quietCnt_r + 3'h1;
	end
	rd_idle_a:
	assert property (!$past(regRdStrobe) |-> regRdData == '0)
		else $error("read data outside its slot");
	unmapped_rd_a:
	assert property (regRdStrobe && regAddr == 8'h80 |=> regRdData == '0)
		else $error("unmapped read not zero");
	irq_pri_a:
	assert property (cpuIrq |-> cpuPriority != PRI_OFF)
		else $error("request with priority off");
	idle_out_a:
	assert property (!cpuIrq |-> cpuPriority == PRI_OFF && cpuVector == '0)
		else $error("idle outputs not cleared");
	vec_range_a:
	assert property (cpuVector < NUM_VEC)
		else $error("vector out of range");
	rst_clear_a:
	assert property (disable iff (1'b0) !resetn |=> !cpuIrq
		&& regRdData == '0 && cpuVectorAddr == '0)
		else $error("outputs not cleared by reset");
	quiet_irq_a:
	assert property (quietCnt_r >= 3'h4 |-> $stable(cpuIrq) && $stable(cpuPriority))
		else $error("request moved without cause");
	quiet_vec_a:
	assert property (quietCnt_r >= 3'h4 |-> $stable(cpuVector)
		&& $stable(cpuVectorAddr))
		else $error("vector moved without cause");
endmodule // vic_chk
bind vectored_interrupt_controller vic_chk i_chk (.mclk, .resetn, .regAddr,
	.regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .periphEvent,
	.extIntPin, .cpuIrq, .cpuVector, .cpuPriority, .cpuVectorAddr);

// file: testbench/periph_model.sv
// peripheral side: one-cycle event pulses and external pin levels
// assumes bench commands change just after a rising edge
`timescale 1ns/10ps
module periph_model
	import vic_pkg::*;
(
	input wire logic mclk,
	input wire logic fire,
	input wire logic [5:0] fireSrc,
	input wire logic [NUM_EXT-1:0] pinLvl,
	output logic [NUM_SRC-1:0] periphEvent,
	output logic [NUM_EXT-1:0] extIntPin
);
	initial periphEvent = '0;
	initial extIntPin = '0;
	// an event is a single high cycle, so the flag must latch it
	always @(posedge mclk) begin
		periphEvent <= fire ? (NUM_SRC'(1) << fireSrc) : '0;
		extIntPin <= pinLvl;
	end
endmodule // periph_model

// file: testbench/vectored_interrupt_controller_test.sv
// self-checking bench for the interrupt controller
// assumes the peripheral model and the port checker beside it
`timescale 1ns/10ps
module vectored_interrupt_controller_test import vic_pkg::*;;
	logic mclk, resetn, regWrStrobe, regRdStrobe, fire, cpuIrq;
	logic [ADDR_W-1:0] regAddr;
	logic [31:0] regWrData, regRdData, cpuVectorAddr;
	logic [NUM_SRC-1:0] periphEvent;
	logic [NUM_EXT-1:0] extIntPin, pinLvl;
	logic [5:0] fireSrc;
	logic [VEC_W-1:0] cpuVector;
	logic [PRI_W-1:0] cpuPriority;
	localparam logic [7:0] OFS_W [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
	int mismatches = 0;
	int nChecks = 0;
	periph_model i_periph (.mclk, .fire, .fireSrc, .pinLvl, .periphEvent,
		.extIntPin);
	vectored_interrupt_controller i_dut (.mclk, .resetn, .regAddr, .regWrData,
		.regWrStrobe, .regRdStrobe, .regRdData, .periphEvent, .extIntPin,
		.cpuIrq, .cpuVector, .cpuPriority, .cpuVectorAddr);
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge mclk);
		regWrStrobe <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge mclk);
		regRdStrobe <= 1'b0;
		#1 chk(regRdData, e);
	endtask
	task out(input logic i, input logic [5:0] v, input logic [2:0] p,
		input logic [31:0] ad);
		repeat (3) @(posedge mclk);
		#1 chk(cpuIrq, i);
		chk(cpuVector, v);
		chk(cpuPriority, p);
		chk(cpuVectorAddr, ad);
	endtask
	task fireEv(input logic [5:0] s);
		@(posedge mclk);
		fire <= 1'b1;
		fireSrc <= s;
		@(posedge mclk);
		fire <= 1'b0;
	endtask
	task endOfTest;
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// a hang counts as a failure
	initial begin
		#100us;
		mismatches++;
		endOfTest;
	end
	initial begin
		{resetn, regWrStrobe, regRdStrobe, fire} = 4'h0;
		{regAddr, regWrData, fireSrc, pinLvl} = '0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		foreach (OFS_W[k]) rd(OFS_W[k], 32'h0);
		rd(8'h80, 32'h0);
		wr(OFS_EN0, 32'hA5A5_5A5A);
		wr(OFS_EN1, 32'h0F0F_0F0F);
		rd(OFS_EN0, 32'hA5A5_5A5A);
		rd(OFS_EN1, 32'h0F0F_0F0F);
		wr(OFS_EN0, 32'h0);
		$display("register test done");
		wr(OFS_LEVEL0, 32'h1500_0000);
		wr(8'h24, 32'h1800_1600);
		wr(OFS_BASE, 32'h0000_1000);
		wr(OFS_CTRL, 32'h0020_0001);
		fireEv(6'h03);
		out(0, 0, 0, 32'h1000);
		rd(OFS_FLAG0, 32'h8);
		wr(OFS_EN0, 32'h8);
		out(1, 3, 5, 32'h1060);
		wr(OFS_FLAG0_SET, 32'h20);
		wr(OFS_EN0, 32'hA8);
		out(1, 5, 5, 32'h10A0);
		wr(OFS_FLAG0_SET, 32'h80);
		out(1, 7, 6, 32'h10E0);
		wr(OFS_FLAG0_CLR, 32'h80);
		wr(OFS_LEVEL0, 32'h1600_0000);
		out(1, 3, 5, 32'h1060);
		$display("priority test done");
		wr(OFS_CTRL, 32'h0020_0000);
		out(1, 0, 5, 32'h1000);
		wr(OFS_EN0, 32'h0);
		out(0, 0, 0, 32'h1000);
		rd(OFS_FLAG0, 32'h28);
		wr(OFS_LEVEL0, 32'h1600_1C00);
		wr(OFS_CTRL, 32'h0020_0201);
		wr(OFS_EN0, 32'h2);
		@(posedge mclk);
		pinLvl <= 5'h02;
		out(1, 1, 7, 32'h1020);
		wr(OFS_FLAG0, 32'h0);
		out(0, 0, 0, 32'h1000);
		$display("mode and pin test done");
		// high sources share the last vector, whose level is word ten
		wr(OFS_LEVEL0 + 8'h28, 32'h0400_0000);
		fireEv(6'd50);
		out(1, 6'h2B, 1, 32'h1560);
		rd(OFS_STATUS, 32'h0001_042B);
		wr(OFS_FLAG1_CLR, 32'h0004_0000);
		out(0, 0, 0, 32'h1000);
		wr(OFS_FLAG1_SET, 32'h0008_0000);
		out(1, 6'h2B, 1, 32'h1560);
		rd(OFS_FLAG1, 32'h0008_0000);
		wr(OFS_CTRL, 32'h0020_0001);
		@(posedge mclk);
		pinLvl <= 5'h00;
		out(1, 1, 7, 32'h1020);
		$display("shared vector and falling pin test done");
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		out(0, 0, 0, 32'h0);
		rd(OFS_EN1, 32'h0);
		$display("mid-run reset test done");
		endOfTest;
	end
endmodule // vectored_interrupt_controller_test
